/* pkg/xct_map.svh */
// Constants for the pin connectivity test block: pin counts, bit positions
// and reset values.
// Assumes it is included by its bare name from the package and xct_top.
`ifndef XCT_MAP_SVH
`define XCT_MAP_SVH

// Count of ordinary pins that feed the chain besides the two mode pins.
`define XCT_OTHER_PINS 88
// Chain input positions of the two mode pins below the ordinary pins.
`define XCT_FRAME_POS 0
`define XCT_LANE0_POS 1
`define XCT_MODE_PINS 2
// Reset values and bit levels.
`define XCT_MODE_RST 1'b0
`define XCT_BUS_PREV_RST 1'b1
`define XCT_CHAIN_RST 1'b0
`define XCT_BIT_LOW 1'b0
`define XCT_BIT_HIGH 1'b1

`endif

/* pkg/xct_pkg.sv */
// Types shared by the pin connectivity test block.
// Assumes the map header sits on the include path.
`default_nettype none
`include "xct_map.svh"

package xct_pkg;

   // Level and enable that together drive one pin.
   typedef struct packed
   {
      logic out;
      logic oe;
   } xct_drive_t;

   // Test mode states, one bit apart.
   typedef enum logic [0:0]
   {
      XCT_NORMAL = 1'b0,
      XCT_CHAIN = 1'b1
   } xct_mode_t;

endpackage : xct_pkg

`default_nettype wire

/* rtl/xct_xnor_stage.sv */
// One stage of the pin chain: the running result is XNORed with one pin.
// Assumes its inputs settle within one clock period.
`timescale 1ns/1ps
`default_nettype none

module xct_xnor_stage
   import xct_pkg::*;
#(
   parameter int WIDTH = 1
)
(
   input wire logic [WIDTH-1:0] carry_in,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] carry_out
);

   assign carry_out = ~(carry_in ^ pin_in);

endmodule : xct_xnor_stage

`default_nettype wire

/* rtl/xct_top.sv */
// Board connectivity test logic: XNOR chain across the device pins.
// Assumes all inputs are synchronous to clk and reset_n is the supply
// power-on reset; the pad ring joins pin_out, pin_oe and the chain pin.
//
// How it works
// - Both mode pins low at a bus reset rise enters chain mode.
// - Either mode pin high at a bus reset rise leaves chain mode.
// - Power-on reset forces chain mode off.
// - In chain mode every pin is an input except the chain output.
// - Any single chain input change toggles the chain output.
// - Bus reset, supplies and the output pin stay out of the chain.
// - Once in chain mode both mode pins are ordinary chain inputs.
// - The chain result drives the general purpose tachometer pin.
// - After exit, toggling former chain inputs leaves the output unchanged.
// - On entry with all inputs low the output reads low.
`timescale 1ns/1ps
`default_nettype none
`include "xct_map.svh"

module xct_top
   import xct_pkg::*;
#(
   parameter int OTHER_PINS = `XCT_OTHER_PINS
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic bus_reset_n,
   input wire logic cycle_frame_n,
   input wire logic addr_data_lane0,
   input wire logic [OTHER_PINS-1:0] pin_in,
   input wire logic [OTHER_PINS-1:0] func_out,
   input wire logic [OTHER_PINS-1:0] func_oe,
   input wire xct_drive_t func_chain_pin,
   output logic [OTHER_PINS-1:0] pin_out,
   output logic [OTHER_PINS-1:0] pin_oe,
   output xct_drive_t chain_output_pin,
   output logic test_mode_active
);

   localparam int CHAIN_LEN = OTHER_PINS + `XCT_MODE_PINS;
   // Seed chosen so that an all-low chain gives a low result.
   localparam logic CHAIN_SEED = (CHAIN_LEN % 2) == 1;

   xct_mode_t mode_q;
   xct_mode_t mode_d;
   logic bus_prev_q;
   logic bus_rise;
   logic [CHAIN_LEN-1:0] chain_in;
   logic [CHAIN_LEN:0] carry;
   logic chain_q;
   logic [OTHER_PINS-1:0] pin_out_q;
   logic [OTHER_PINS-1:0] pin_oe_q;
   xct_drive_t chain_pin_q;
   logic in_chain;

   assign in_chain = (mode_q == XCT_CHAIN);
   assign bus_rise = bus_reset_n && !bus_prev_q;

   // The bus reset is sampled for its rising edge only.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         bus_prev_q <= `XCT_BUS_PREV_RST;
      end
      else
      begin
         bus_prev_q <= bus_reset_n;
      end
   end

   // Mode pins are judged only at the bus reset rise.
   always_comb
   begin
      mode_d = mode_q;
      if (bus_rise)
      begin
         if (!cycle_frame_n && !addr_data_lane0)
         begin
            mode_d = XCT_CHAIN;
         end
         else
         begin
            mode_d = XCT_NORMAL;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         mode_q <= XCT_NORMAL;
      end
      else
      begin
         mode_q <= mode_d;
      end
   end

   // Chain inputs: ordinary pins plus both mode pins; bus reset is left out.
   assign chain_in = {pin_in, addr_data_lane0, cycle_frame_n};
   assign carry[0] = CHAIN_SEED;

   genvar g;
   generate
      for (g = 0; g < CHAIN_LEN; g++)
      begin : g_chain
         xct_xnor_stage #(
            .WIDTH(1)
         ) u_stage (
            .carry_in(carry[g]),
            .pin_in(chain_in[g]),
            .carry_out(carry[g+1])
         );
      end
   endgenerate

   // The chain result is captured only in chain mode and frozen otherwise.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         chain_q <= `XCT_CHAIN_RST;
      end
      else if (in_chain)
      begin
         chain_q <= carry[CHAIN_LEN];
      end
   end

   // Pin drivers: all released in chain mode, normal functions otherwise.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         pin_out_q <= '0;
         pin_oe_q <= '0;
      end
      else if (in_chain)
      begin
         pin_out_q <= '0;
         pin_oe_q <= '0;
      end
      else
      begin
         pin_out_q <= func_out;
         pin_oe_q <= func_oe;
      end
   end

   // Chain output pin: chain result in chain mode, normal function otherwise.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         chain_pin_q <= '{out: `XCT_BIT_LOW, oe: `XCT_BIT_LOW};
      end
      else if (in_chain)
      begin
         chain_pin_q <= '{out: carry[CHAIN_LEN], oe: `XCT_BIT_HIGH};
      end
      else
      begin
         chain_pin_q <= func_chain_pin;
      end
   end

   assign pin_out = pin_out_q;
   assign pin_oe = pin_oe_q;
   assign chain_output_pin = chain_pin_q;
   assign test_mode_active = in_chain;

   // Checks.
   property p_enter;
      @(posedge clk) disable iff (!reset_n)
      bus_rise && !cycle_frame_n && !addr_data_lane0 |=> in_chain;
   endproperty
   a_enter: assert property (p_enter) else $error("chain mode not entered");

   property p_exit;
      @(posedge clk) disable iff (!reset_n)
      bus_rise && (cycle_frame_n || addr_data_lane0) |=> !in_chain;
   endproperty
   a_exit: assert property (p_exit) else $error("chain mode not left");

   property p_por;
      @(posedge clk) disable iff (!reset_n)
      $rose(reset_n) |-> !in_chain && !chain_pin_q.oe;
   endproperty
   a_por: assert property (p_por) else $error("power-on reset left chain mode");

   property p_detach;
      @(posedge clk) disable iff (!reset_n)
      in_chain ##1 in_chain |-> pin_oe == '0 && chain_output_pin.oe;
   endproperty
   a_detach: assert property (p_detach) else $error("pin driven in chain mode");

   property p_toggle;
      @(posedge clk) disable iff (!reset_n)
      in_chain && $past(in_chain) && $countones(chain_in ^ $past(chain_in)) == 1
      |=> chain_output_pin.out != $past(chain_output_pin.out);
   endproperty
   a_toggle: assert property (p_toggle) else $error("chain output did not toggle");

   property p_excluded;
      @(posedge clk) disable iff (!reset_n)
      in_chain && $past(in_chain) && chain_in == $past(chain_in) && $changed(bus_reset_n)
      |=> $stable(chain_q);
   endproperty
   a_excluded: assert property (p_excluded) else $error("bus reset moved chain");

   property p_lane;
      @(posedge clk) disable iff (!reset_n)
      in_chain && $past(in_chain) && $changed(addr_data_lane0) && $stable(cycle_frame_n)
      && $stable(pin_in) |=> chain_q != $past(chain_q);
   endproperty
   a_lane: assert property (p_lane) else $error("lane zero not in chain");

   property p_result;
      @(posedge clk) disable iff (!reset_n)
      in_chain |=> chain_output_pin.out == ^$past(chain_in) && chain_output_pin.out == chain_q;
   endproperty
   a_result: assert property (p_result) else $error("chain result not on pin");

   property p_after_exit;
      @(posedge clk) disable iff (!reset_n)
      !in_chain ##1 (!in_chain && $stable(func_chain_pin)) |=> $stable(chain_output_pin);
   endproperty
   a_after_exit: assert property (p_after_exit) else $error("output moved after exit");

   property p_initial_low;
      @(posedge clk) disable iff (!reset_n)
      $rose(in_chain) && chain_in == '0 |=> chain_output_pin.out == `XCT_BIT_LOW;
   endproperty
   a_initial_low: assert property (p_initial_low) else $error("all-low chain not low");

   property p_hold;
      @(posedge clk) disable iff (!reset_n)
      !bus_rise |=> $stable(mode_q);
   endproperty
   a_hold: assert property (p_hold) else $error("mode changed without bus reset rise");

   c_enter: cover property (@(posedge clk) disable iff (!reset_n) $rose(in_chain));
   c_exit: cover property (@(posedge clk) disable iff (!reset_n) $fell(in_chain));
   c_toggle: cover property (@(posedge clk) disable iff (!reset_n)
      in_chain ##1 $changed(chain_output_pin.out));
   c_por: cover property (@(posedge clk) in_chain ##1 !reset_n);

endmodule : xct_top

`default_nettype wire

/* test/xct_tester.sv */
// Board test equipment model: drives the mode pins, bus reset and chain pins.
// Assumes the bench calls its tasks and watches the chain output itself.
`timescale 1ns/1ps
`default_nettype none

module xct_tester
   import xct_pkg::*;
#(
   parameter int N = 8
)
(
   input wire logic clk,
   output logic bus_reset_n,
   output logic cycle_frame_n,
   output logic addr_data_lane0,
   output logic [N-1:0] pin_in
);
   initial
   begin
      bus_reset_n = 1'b1;
      cycle_frame_n = 1'b1;
      addr_data_lane0 = 1'b1;
      pin_in = '0;
   end

   // Sets every chain input level at once.
   task automatic set_pins(input logic [N+1:0] v);
      @(posedge clk);
      #1;
      {pin_in, addr_data_lane0, cycle_frame_n} = v;
   endtask : set_pins

   // Pulses bus reset with the mode pins held across the rising edge.
   task automatic pulse(input logic frame, input logic lane0);
      @(posedge clk);
      #1;
      bus_reset_n = 1'b0;
      cycle_frame_n = frame;
      addr_data_lane0 = lane0;
      @(posedge clk);
      #1;
      bus_reset_n = 1'b1;
      repeat (4) @(posedge clk);
   endtask : pulse
endmodule : xct_tester

`default_nettype wire

/* test/xct_top_bench.sv */
// Self-checking bench for the pin chain block with a test equipment model.
// Assumes the design registers its outputs one cycle after the inputs.
`timescale 1ns/1ps
`default_nettype none
`define XCT_CHECK(a, b, m) check_count++; if ((a) !== (b)) begin errors++; $display("[FAIL] %0t %s", $time, m); end

module xct_top_bench
   import xct_pkg::*;
();
   localparam int N = 8;
   typedef struct {int due; logic [3:0] exp;} xct_note_t;
   logic clk, reset_n, bus_reset_n, cycle_frame_n, addr_data_lane0, mode, fco;
   logic [N-1:0] pin_in, func_out, func_oe, pin_out, pin_oe;
   logic [N+1:0] cur;
   xct_drive_t func_chain_pin, chain_output_pin;
   logic test_mode_active;
   logic [3:0] obs;
   xct_note_t notes[$];
   xct_note_t n;
   int cyc = 0, errors = 0, check_count = 0, seed = 20, i;

   assign obs = {test_mode_active, |pin_oe, chain_output_pin.oe, chain_output_pin.out};

   xct_top #(.OTHER_PINS(N)) DUT (.clk(clk), .reset_n(reset_n), .bus_reset_n(bus_reset_n),
      .cycle_frame_n(cycle_frame_n), .addr_data_lane0(addr_data_lane0), .pin_in(pin_in),
      .func_out(func_out), .func_oe(func_oe), .func_chain_pin(func_chain_pin),
      .pin_out(pin_out), .pin_oe(pin_oe), .chain_output_pin(chain_output_pin),
      .test_mode_active(test_mode_active));

   xct_tester #(.N(N)) tester (.clk(clk), .bus_reset_n(bus_reset_n),
      .cycle_frame_n(cycle_frame_n), .addr_data_lane0(addr_data_lane0), .pin_in(pin_in));

   always #20 clk = ~clk;

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
   end

   always @(negedge clk)
   begin
      if (notes.size() > 0 && notes[0].due == cyc)
      begin
         n = notes.pop_front();
         `XCT_CHECK(obs, n.exp, "chain pin or mode mismatch")
         `XCT_CHECK(pin_out, n.exp[3] ? '0 : func_out, "pin level mismatch")
         `XCT_CHECK(pin_oe, n.exp[3] ? '0 : func_oe, "pin enable mismatch")
      end
   end

   task automatic apply(input logic [N+1:0] v);
      tester.set_pins(v);
      notes.push_back('{cyc + 1, mode ? {3'b101, ^v} : {3'b011, fco}});
   endtask : apply

   task automatic test_done;
      if (notes.size() > 0)
         errors++;
      if (errors == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done

   initial
   begin
      clk = 1'b0;
      reset_n = 1'b0;
      mode = 1'b0;
      fco = 1'($random(seed));
      func_out = N'($random(seed));
      func_oe = '1;
      func_chain_pin = '{out: fco, oe: 1'b1};
      repeat (12) @(posedge clk);
      #1;
      reset_n = 1'b1;
      for (i = 0; i < 3; i++) apply((N+2)'($random(seed)));
      apply('0);
      tester.pulse(1'b0, 1'b0);
      mode = 1'b1;
      cur = '0;
      apply(cur);
      for (i = N + 1; i >= 0; i--)
      begin
         cur[i] = 1'b1;
         apply(cur);
      end
      for (i = 0; i <= N + 1; i++)
      begin
         cur[i] = 1'b0;
         apply(cur);
      end
      for (i = 0; i < 20; i++) apply((N+2)'($random(seed)));
      for (i = 1; i < 4; i++)
      begin
         tester.pulse(i[1], i[0]);
         mode = 1'b0;
         repeat (3) apply((N+2)'($random(seed)));
         tester.pulse(1'b0, 1'b0);
         mode = 1'b1;
         repeat (3) apply((N+2)'($random(seed)));
      end
      @(posedge clk);
      #1;
      reset_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      reset_n = 1'b1;
      mode = 1'b0;
      repeat (3) apply((N+2)'($random(seed)));
      repeat (3) @(posedge clk);
      test_done;
   end

   initial
   begin
      repeat (5000) @(posedge clk);
      errors++;
      test_done;
   end
endmodule : xct_top_bench

`default_nettype wire
